// [pkg/svcr_pkg.sv]
// svcr_pkg: offsets, field positions and reset values of the config bank
`default_nettype none
package svcr_pkg;
	// register offsets in configuration space
	localparam logic [7:0] OFS_MSI_DATA = 8'h58;
	localparam logic [7:0] OFS_VND_HDR = 8'h64;
	localparam logic [7:0] OFS_TEST_A = 8'h68;
	localparam logic [7:0] OFS_TEST_B = 8'h6c;
	localparam logic [7:0] OFS_TIMERS = 8'h70;
	localparam logic [7:0] OFS_OPMODE = 8'h74;
	// vendor capability header constants
	localparam logic [7:0] VND_CAP_ID = 8'h09;
	localparam logic [7:0] VND_NEXT_PTR = 8'hb0;
	localparam logic [15:0] VND_LENGTH = 16'h0034;
	// timer word field positions
	localparam int RPL_LSB = 0;
	localparam int RPL_W = 12;
	localparam int RPL_EN_BIT = 12;
	localparam int PM_DIS_BIT = 13;
	localparam int MSI_DIS_BIT = 14;
	localparam int ACK_LSB = 16;
	localparam int ACK_W = 14;
	localparam int ACK_EN_BIT = 30;
	localparam int VGA_BIT = 31;
	// operation mode field positions
	localparam int SF_BIT = 0;
	localparam int CT_LSB = 1;
	localparam int ARB_BIT = 3;
	// reset values
	localparam logic [15:0] MSI_DATA_RST = 16'h0000;
	localparam logic [31:0] TEST_A_RST = 32'h0400_1060;
	localparam logic [31:0] TEST_B_RST = 32'h0000_0800;
	localparam logic [31:0] TIMERS_RST = 32'h8000_0000;
	localparam logic [3:0] OPMODE_RST = 4'h2;
	// writable bits of the timer word: host side and default loader side
	localparam logic [31:0] TIMERS_HOST_MASK = 32'h7fff_1fff;
	localparam logic [31:0] TIMERS_LD_MASK = 32'hffff_7fff;
	// message data occupies the low half only
	localparam logic [31:0] MSI_DATA_MASK = 32'h0000_ffff;
	localparam logic [31:0] OPMODE_MASK = 32'h0000_000f;
	localparam int NPORT = 4;
endpackage
`default_nettype wire

// [rtl/svcr_rr_arb.sv]
// svcr_rr_arb: round-robin port arbiter with credit-aware moves
`default_nettype none
module svcr_rr_arb
	import svcr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// policy
	input wire logic hold_mode,
	// port requests and credit state
	input wire logic [NPORT-1:0] port_req,
	input wire logic [NPORT-1:0] port_credit_ok,
	// grant
	output logic [NPORT-1:0] port_grant,
	output logic grant_valid
);
	logic [NPORT-1:0] gnt_q; // one-hot grant
	logic [1:0] idx_q; // index of last granted port
	logic gvld_q;
	logic keep; // stay on current port
	logic [NPORT-1:0] elig; // requesting and credit sufficient
	logic [NPORT-1:0] pick;

	// nearest eligible port after cur; cur itself comes last
	function automatic logic [NPORT-1:0] rr_pick(
		input logic [NPORT-1:0] e, input logic [1:0] cur);
		logic [NPORT-1:0] g;
		logic [1:0] k;
		g = '0;
		for (int i = NPORT; i >= 1; i--) begin
			k = cur + 2'(i);
			if (e[k]) begin
				g = 4'h1 << k;
			end
		end
		return g;
	endfunction

	// one-hot to index
	function automatic logic [1:0] oh_idx(input logic [NPORT-1:0] g);
		logic [1:0] r;
		r = '0;
		for (int i = 0; i < NPORT; i++) begin
			if (g[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	// hold mode ignores credit for the owner; normal mode needs credit
	always_comb begin
		elig = port_req & port_credit_ok;
		if (hold_mode) begin
			keep = gvld_q && |(port_req & gnt_q); // R13
		end else begin
			keep = gvld_q && |(elig & gnt_q); // R14
		end
		pick = rr_pick(elig, idx_q); // R14
	end

	// grant update, one slot per cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			gnt_q <= '0;
			idx_q <= 2'h3;
			gvld_q <= 1'b0;
		end else if (!keep) begin
			gnt_q <= pick;
			gvld_q <= |pick;
			if (|pick) begin
				idx_q <= oh_idx(pick);
			end
		end
	end

	assign port_grant = gnt_q;
	assign grant_valid = gvld_q;
endmodule
`default_nettype wire

// [rtl/svcr_msi_gen.sv]
// svcr_msi_gen: turns an interrupt trigger into one MSI memory write
`default_nettype none
module svcr_msi_gen (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// message setup
	input wire logic msi_enable,
	input wire logic [29:0] msi_addr,
	input wire logic [15:0] msi_data,
	input wire logic msi_trigger,
	// memory write request
	output logic mwr_valid,
	input wire logic mwr_ready,
	output logic [31:0] mwr_addr,
	output logic [15:0] mwr_data
);
	typedef enum logic [1:0] {
		SVCR_IDLE = 2'b00,
		SVCR_SEND = 2'b01
	} svcr_msi_st_t;

	svcr_msi_st_t st_q;
	logic pend_q; // trigger seen while a write was still out
	logic [31:0] addr_q;
	logic [15:0] data_q;
	logic go; // start a write this cycle

	// a trigger with MSI off is dropped, no INTx fallback here
	assign go = msi_enable && (msi_trigger || pend_q);

	// sequencing
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= SVCR_IDLE;
		end else begin
			case (st_q)
				SVCR_IDLE: begin
					if (go) begin
						st_q <= SVCR_SEND;
					end
				end
				SVCR_SEND: begin
					if (mwr_ready) begin
						st_q <= SVCR_IDLE;
					end
				end
				default: st_q <= SVCR_IDLE;
			endcase
		end
	end

	// a trigger during SEND is remembered; set wins over the clear
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pend_q <= 1'b0;
		end else if (st_q == SVCR_SEND && msi_trigger && msi_enable) begin
			pend_q <= 1'b1;
		end else if (st_q == SVCR_IDLE && go) begin
			pend_q <= 1'b0;
		end
	end

	// address forced to dword alignment, captured at start
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= '0;
			data_q <= '0;
		end else if (st_q == SVCR_IDLE && go) begin
			addr_q <= {msi_addr, 2'b00}; // R17
			data_q <= msi_data; // R17
		end
	end

	assign mwr_valid = (st_q == SVCR_SEND);
	assign mwr_addr = addr_q;
	assign mwr_data = data_q;
endmodule
`default_nettype wire

// [rtl/svcr_regs.sv]
// svcr_regs: vendor config register bank of the upstream port
// Notes on behaviour
// [R1] header low byte reads capability id 09h
// [R2] header next pointer reads B0h
// [R3] header upper half reads length 0034h
// [R4] 12-bit user replay value, resets zero
// [R5] replay enable bit selects user replay value
// [R6] 14-bit user ack latency value, resets zero
// [R7] ack enable bit selects user ack value
// [R8] pm and msi disable bits read-only, zero
// [R9] vga decode enable read-only, resets one
// [R10] smbus or eeprom loader overwrites defaults
// [R11] mode bit0 set store-forward, else cut-through
// [R12] bits 2:1 pick cut-through threshold, reset 01b
// [R13] bit3 set: arbiter holds pending port
// [R14] bit3 clear: move only to credited requester
// [R15] test word a at 68h, reset 0400_1060h
// [R16] test word b at 6Ch, reset 0000_0800h
// [R17] msi write to aligned address with data
// [R18] override clear keeps the built-in timer value
`default_nettype none
module svcr_regs
	import svcr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// configuration space access
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [3:0] cfg_be,
	output logic [31:0] cfg_rdata,
	output logic cfg_rd_valid,
	// default loader (smbus or eeprom)
	input wire logic dflt_ld_en,
	input wire logic [7:0] dflt_ld_addr,
	input wire logic [31:0] dflt_ld_data,
	// link timer values
	input wire logic [11:0] builtin_replay,
	input wire logic [13:0] builtin_ack_lat,
	output logic [11:0] replay_timeout,
	output logic [13:0] ack_latency,
	// capability controls
	output logic pm_cap_disable,
	output logic msi_cap_disable,
	output logic vga_decode_en,
	// forwarding mode and test words
	output logic store_forward,
	output logic [1:0] ct_threshold,
	output logic [31:0] test_word_a,
	output logic [31:0] test_word_b,
	// port arbitration
	input wire logic [NPORT-1:0] port_req,
	input wire logic [NPORT-1:0] port_credit_ok,
	output logic [NPORT-1:0] port_grant,
	output logic grant_valid,
	// msi
	input wire logic msi_enable,
	input wire logic [29:0] msi_addr,
	input wire logic msi_trigger,
	output logic mwr_valid,
	input wire logic mwr_ready,
	output logic [31:0] mwr_addr,
	output logic [15:0] mwr_data
);
	logic [15:0] msi_data_q; // message data
	logic [31:0] test_a_q;
	logic [31:0] test_b_q;
	logic [31:0] timers_q; // replay and ack latency word
	logic [3:0] opmode_q; // forwarding and arbitration mode
	logic [31:0] rdata_q;
	logic rvld_q;
	logic [11:0] replay_q;
	logic [13:0] ack_q;
	logic [31:0] rd_word; // read mux
	logic [31:0] be_mask; // byte enables as bit mask
	logic [31:0] msi_wr_word; // message data word after a host write
	logic [31:0] opm_wr_word; // mode word after a host write

	// expand byte enables to a bit mask
	function automatic logic [31:0] be_bits(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[8*i +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	// merge new bits under a mask
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [31:0] m);
		return (old & ~m) | (nw & m);
	endfunction

	// host write hit
	function automatic logic hwr(input logic en, input logic [7:0] a,
		input logic [7:0] o);
		return en && (a == o);
	endfunction

	assign be_mask = be_bits(cfg_be);

	// merged write words, narrowed where they land
	// reserved upper bits are masked off, so they always read zero
	assign msi_wr_word = merge({16'h0000, msi_data_q}, cfg_wdata,
		be_mask & MSI_DATA_MASK);
	assign opm_wr_word = merge({28'h000_0000, opmode_q}, cfg_wdata,
		be_mask & OPMODE_MASK);

	// message data, upper half reserved
	// the writer copies this when a write starts, so a rewrite while a
	// message is out changes only the next one
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			msi_data_q <= MSI_DATA_RST;
		end else if (hwr(cfg_wr_en, cfg_addr, OFS_MSI_DATA)) begin
			msi_data_q <= msi_wr_word[15:0]; // R17
		end
	end

	// test words, plain storage
	// no side effects; any value software parks here reads back and drives test_word_a or test_word_b
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			test_a_q <= TEST_A_RST; // R15
			test_b_q <= TEST_B_RST; // R16
		end else if (cfg_wr_en) begin
			if (cfg_addr == OFS_TEST_A) begin
				test_a_q <= merge(test_a_q, cfg_wdata, be_mask); // R15
			end
			if (cfg_addr == OFS_TEST_B) begin
				test_b_q <= merge(test_b_q, cfg_wdata, be_mask); // R16
			end
		end
	end

	// timer word; the loader may also rewrite the read-only bits
	// loader wins a same-cycle collision so a boot load is not torn
	// bit 15 is reserved: neither side can store it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			timers_q <= TIMERS_RST; // R4 R6 R8 R9
		end else if (hwr(dflt_ld_en, dflt_ld_addr, OFS_TIMERS)) begin
			timers_q <= dflt_ld_data & TIMERS_LD_MASK; // R10
		end else if (hwr(cfg_wr_en, cfg_addr, OFS_TIMERS)) begin
			// host cannot touch bits 13, 14, 31
			timers_q <= merge(timers_q, cfg_wdata,
				be_mask & TIMERS_HOST_MASK); // R4 R6 R8 R9
		end
	end

	// operation mode
	// only the low nibble is stored; the rest of the word reads zero
	// the loader copies the nibble whole, a host write follows lane 0
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			opmode_q <= OPMODE_RST; // R11 R12 R14
		end else if (hwr(dflt_ld_en, dflt_ld_addr, OFS_OPMODE)) begin
			opmode_q <= dflt_ld_data[3:0]; // R10
		end else if (hwr(cfg_wr_en, cfg_addr, OFS_OPMODE)) begin
			opmode_q <= opm_wr_word[3:0]; // R11 R12 R13 R14
		end
	end

	// effective timers; built-in value unless override enabled
	// registered so a split host write cannot glitch the link timers;
	// the price is one cycle of lag after an enable bit flips
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			replay_q <= '0;
			ack_q <= '0;
		end else begin
			replay_q <= timers_q[RPL_EN_BIT] ?
				timers_q[RPL_LSB +: RPL_W] : builtin_replay; // R5 R18
			ack_q <= timers_q[ACK_EN_BIT] ?
				timers_q[ACK_LSB +: ACK_W] : builtin_ack_lat; // R7 R18
		end
	end

	// read mux; unmapped offsets read zero
	// offsets decode in full, so no register aliases another
	always_comb begin
		case (cfg_addr)
			OFS_MSI_DATA: rd_word = {16'h0000, msi_data_q};
			OFS_VND_HDR: rd_word = {VND_LENGTH, VND_NEXT_PTR,
				VND_CAP_ID}; // R1 R2 R3
			OFS_TEST_A: rd_word = test_a_q;
			OFS_TEST_B: rd_word = test_b_q;
			OFS_TIMERS: rd_word = timers_q;
			OFS_OPMODE: rd_word = {28'h000_0000, opmode_q};
			default: rd_word = '0;
		endcase
	end

	// read data registered, valid one cycle after the strobe
	// rdata holds the last read, so software may take it late
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
			rvld_q <= 1'b0;
		end else begin
			rvld_q <= cfg_rd_en;
			if (cfg_rd_en) begin
				rdata_q <= rd_word;
			end
		end
	end

	// arbiter follows the mode bit live
	// not latched per packet: a flip of the mode bit acts on the
	// very next arbitration slot
	svcr_rr_arb u_arb (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.hold_mode(opmode_q[ARB_BIT]),
		.port_req(port_req),
		.port_credit_ok(port_credit_ok),
		.port_grant(port_grant),
		.grant_valid(grant_valid)
	);

	// message writer
	// the message address comes from the capability above this bank
	svcr_msi_gen u_msi (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.msi_enable(msi_enable),
		.msi_addr(msi_addr),
		.msi_data(msi_data_q),
		.msi_trigger(msi_trigger),
		.mwr_valid(mwr_valid),
		.mwr_ready(mwr_ready),
		.mwr_addr(mwr_addr),
		.mwr_data(mwr_data)
	);

	// outputs straight from the stored words
	assign cfg_rdata = rdata_q;
	assign cfg_rd_valid = rvld_q;
	assign replay_timeout = replay_q;
	assign ack_latency = ack_q;
	assign pm_cap_disable = timers_q[PM_DIS_BIT]; // R8
	assign msi_cap_disable = timers_q[MSI_DIS_BIT]; // R8
	assign vga_decode_en = timers_q[VGA_BIT]; // R9
	assign store_forward = opmode_q[SF_BIT]; // R11
	assign ct_threshold = opmode_q[CT_LSB +: 2]; // R12
	assign test_word_a = test_a_q;
	assign test_word_b = test_b_q;

	// checks
	// reset is asynchronous; checks that look a cycle back start only
	// from a cycle with nrst sampled high
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	logic hdr_rd;
	logic host_t;
	logic host_m;
	assign hdr_rd = cfg_rd_en && cfg_addr == OFS_VND_HDR;
	assign host_t = hwr(cfg_wr_en, cfg_addr, OFS_TIMERS) &&
		!hwr(dflt_ld_en, dflt_ld_addr, OFS_TIMERS);
	assign host_m = hwr(cfg_wr_en, cfg_addr, OFS_OPMODE) && cfg_be[0] &&
		!hwr(dflt_ld_en, dflt_ld_addr, OFS_OPMODE);

	// header reads, the timer word and the loader
	hdr_id_a: assert property (hdr_rd |=> cfg_rd_valid && // R1
		cfg_rdata[7:0] == 8'h09) else $error("bad cap id");
	hdr_next_a: assert property (hdr_rd |=> // R2
		cfg_rdata[15:8] == 8'hb0) else $error("bad next ptr");
	hdr_len_a: assert property (hdr_rd |=> // R3
		cfg_rdata[31:16] == 16'h0034) else $error("bad length");
	replay_user_a: assert property (host_t && cfg_be[1:0] == 2'b11 |=> // R4
		timers_q[11:0] == $past(cfg_wdata[11:0]))
		else $error("replay field not written");
	replay_sel_a: assert property (nrst |=> replay_timeout == // R5
		($past(timers_q[12]) ? $past(timers_q[11:0]) :
		$past(builtin_replay))) else $error("replay mux wrong");
	ack_user_a: assert property (host_t && cfg_be[3:2] == 2'b11 |=> // R6
		timers_q[29:16] == $past(cfg_wdata[29:16]))
		else $error("ack field not written");
	ack_sel_a: assert property (timers_q[30] ##1 $stable(timers_q) |-> // R7
		ack_latency == timers_q[29:16])
		else $error("ack override ignored");
	ro_bits_a: assert property (host_t |=> $stable(timers_q[14:13])) // R8
		else $error("read-only disable bits changed");
	vga_ro_a: assert property (host_t |=> $stable(vga_decode_en)) // R9
		else $error("vga enable written by host");
	ld_wins_a: assert property ( // R10
		hwr(dflt_ld_en, dflt_ld_addr, OFS_TIMERS) |=>
		timers_q == ($past(dflt_ld_data) & 32'hffff_7fff))
		else $error("default load lost");
	ld_ro_a: assert property ( // R10 R8
		hwr(dflt_ld_en, dflt_ld_addr, OFS_TIMERS) |=>
		pm_cap_disable == $past(dflt_ld_data[13]) &&
		msi_cap_disable == $past(dflt_ld_data[14]))
		else $error("loader missed disable bits");
	opm_ld_a: assert property ( // R10
		hwr(dflt_ld_en, dflt_ld_addr, OFS_OPMODE) |=>
		{ct_threshold, store_forward} == $past(dflt_ld_data[2:0]))
		else $error("mode load lost");
	// mode, arbiter, test words, message writer and built-in replay
	sf_mode_a: assert property (host_m |=> // R11
		store_forward == $past(cfg_wdata[0]))
		else $error("store-forward bit wrong");
	ct_thr_a: assert property (host_m |=> // R12
		ct_threshold == $past(cfg_wdata[2:1]))
		else $error("threshold wrong");
	arb_hold_a: assert property (opmode_q[3] && grant_valid && // R13
		|(port_req & port_grant) |=> $stable(port_grant))
		else $error("hold mode left pending port");
	arb_credit_a: assert property (!$past(opmode_q[3]) && // R14
		grant_valid && $changed(port_grant) |->
		|($past(port_req & port_credit_ok) & port_grant))
		else $error("moved to port without credit");
	arb_onehot_a: assert property ($onehot0(port_grant) && // R14
		grant_valid == |port_grant) else $error("grant not one-hot");
	test_a_wr_a: assert property ( // R15
		hwr(cfg_wr_en, cfg_addr, OFS_TEST_A) && cfg_be == 4'hf |=>
		test_word_a == $past(cfg_wdata))
		else $error("test word a not written");
	test_b_wr_a: assert property ( // R16
		hwr(cfg_wr_en, cfg_addr, OFS_TEST_B) && cfg_be == 4'hf |=>
		test_word_b == $past(cfg_wdata))
		else $error("test word b not written");
	msi_send_a: assert property (msi_trigger && msi_enable && // R17
		!mwr_valid |-> ##[1:2] mwr_valid && mwr_addr[1:0] == 2'b00 &&
		mwr_data == $past(msi_data_q))
		else $error("msi write missing");
	msi_hold_a: assert property (mwr_valid && !mwr_ready |=> // R17
		mwr_valid && $stable(mwr_addr))
		else $error("msi request dropped");
	msi_drop_a: assert property (!msi_enable && !mwr_valid |=> // R17
		!mwr_valid) else $error("msi sent while disabled");
	dflt_keep_a: assert property (nrst && !timers_q[12] ##1 // R18
		!timers_q[12] |-> replay_timeout == $past(builtin_replay))
		else $error("built-in replay not used");

	ld_cov_c: cover property (hwr(dflt_ld_en, dflt_ld_addr, OFS_OPMODE));
	msi_cov_c: cover property (mwr_valid && mwr_ready);
	hold_cov_c: cover property (opmode_q[3] && grant_valid &&
		|(port_req & port_grant & ~port_credit_ok));
	hdr_cov_c: cover property (hdr_rd ##1 cfg_rd_valid);
	arb_move_c: cover property (grant_valid && $changed(port_grant));
endmodule
`default_nettype wire

// [dv/svcr_mwr_sink.sv]
// svcr_mwr_sink: far-side model that accepts msi memory writes
`default_nettype none
module svcr_mwr_sink (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// answer delay in cycles, zero answers promptly
	input wire logic [3:0] delay,
	// memory write request from the bank
	input wire logic mwr_valid,
	input wire logic [31:0] mwr_addr,
	input wire logic [15:0] mwr_data,
	output logic mwr_ready,
	// last accepted write and a running count
	output logic [31:0] got_addr,
	output logic [15:0] got_data,
	output logic [7:0] n_wr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q; // cycles spent on the current request
	// ready is a one-cycle pulse, so a held request is taken only once
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mwr_ready <= 1'b0;
			wait_q <= 4'h0;
			got_addr <= 32'h0000_0000;
			got_data <= 16'h0000;
			n_wr <= 8'h00;
		end else begin
			mwr_ready <= 1'b0;
			if (mwr_valid && !mwr_ready) begin
				// stall for the set delay before answering
				if (wait_q == delay) begin
					mwr_ready <= 1'b1;
					wait_q <= 4'h0;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
			// data taken at the edge where ready is seen high
			if (mwr_valid && mwr_ready) begin
				got_addr <= mwr_addr;
				got_data <= mwr_data;
				n_wr <= n_wr + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/test_svcr_regs.sv]
// test_svcr_regs: self-checking bench of the vendor config bank
`default_nettype none
module test_svcr_regs
	import svcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// clock, reset and bus
	logic sys_clk, nrst, cfg_wr_en, cfg_rd_en, cfg_rd_valid, dflt_ld_en;
	logic [7:0] cfg_addr, dflt_ld_addr;
	logic [31:0] cfg_wdata, cfg_rdata, dflt_ld_data, test_word_a, test_word_b;
	logic [3:0] cfg_be, port_req, port_credit_ok, port_grant, snk_delay;
	// timers, modes, arbiter and msi
	logic [11:0] builtin_replay, replay_timeout;
	logic [13:0] builtin_ack_lat, ack_latency;
	logic pm_cap_disable, msi_cap_disable, vga_decode_en, store_forward;
	logic [1:0] ct_threshold;
	logic grant_valid, msi_enable, msi_trigger, mwr_valid, mwr_ready;
	logic [29:0] msi_addr;
	logic [31:0] mwr_addr, got_addr;
	logic [15:0] mwr_data, got_data;
	logic [7:0] n_wr, n0;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	int i;
	svcr_regs dut (.sys_clk(sys_clk), .nrst(nrst), .cfg_wr_en(cfg_wr_en),
		.cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
		.dflt_ld_en(dflt_ld_en), .dflt_ld_addr(dflt_ld_addr),
		.dflt_ld_data(dflt_ld_data), .builtin_replay(builtin_replay),
		.builtin_ack_lat(builtin_ack_lat), .replay_timeout(replay_timeout),
		.ack_latency(ack_latency), .pm_cap_disable(pm_cap_disable),
		.msi_cap_disable(msi_cap_disable), .vga_decode_en(vga_decode_en),
		.store_forward(store_forward), .ct_threshold(ct_threshold),
		.test_word_a(test_word_a), .test_word_b(test_word_b),
		.port_req(port_req), .port_credit_ok(port_credit_ok),
		.port_grant(port_grant), .grant_valid(grant_valid),
		.msi_enable(msi_enable), .msi_addr(msi_addr),
		.msi_trigger(msi_trigger), .mwr_valid(mwr_valid),
		.mwr_ready(mwr_ready), .mwr_addr(mwr_addr), .mwr_data(mwr_data));
	svcr_mwr_sink snk (.sys_clk(sys_clk), .nrst(nrst), .delay(snk_delay),
		.mwr_valid(mwr_valid), .mwr_addr(mwr_addr), .mwr_data(mwr_data),
		.mwr_ready(mwr_ready), .got_addr(got_addr), .got_data(got_data),
		.n_wr(n_wr));
	// 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// verdict and end of run, reached from the sequence or the timeout
	task automatic results();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// hang guard, far above the length of the sequence
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			results();
		end
	end
	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// wait n edges, then settle past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// one host write, strobe held a single cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge sys_clk);
		cfg_wr_en <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_be <= be;
		@(posedge sys_clk);
		cfg_wr_en <= 1'b0;
	endtask
	// one host read, data checked in the valid cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		cfg_rd_en <= 1'b1;
		cfg_addr <= a;
		@(posedge sys_clk);
		cfg_rd_en <= 1'b0;
		#1;
		chk("rd_valid", {31'h0, cfg_rd_valid}, 32'h0000_0001);
		chk("rdata", cfg_rdata, exp);
	endtask
	// one loader write
	task automatic ld(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		dflt_ld_en <= 1'b1;
		dflt_ld_addr <= a;
		dflt_ld_data <= d;
		@(posedge sys_clk);
		dflt_ld_en <= 1'b0;
	endtask
	// main sequence
	initial begin
		nrst = 1'b0;
		{cfg_wr_en, cfg_rd_en, dflt_ld_en, msi_enable, msi_trigger} = 5'h00;
		cfg_addr = 8'h00;
		cfg_wdata = 32'h0000_0000;
		cfg_be = 4'hf;
		dflt_ld_addr = 8'h00;
		dflt_ld_data = 32'h0000_0000;
		builtin_replay = 12'h0a5;
		builtin_ack_lat = 14'h1234;
		port_req = 4'h0;
		port_credit_ok = 4'h0;
		msi_addr = 30'h0000_0000;
		snk_delay = 4'h0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		// reset values and the fixed header
		rd(OFS_MSI_DATA, 32'h0000_0000);
		rd(OFS_VND_HDR, 32'h0034_b009);
		rd(OFS_TEST_A, 32'h0400_1060);
		rd(OFS_TEST_B, 32'h0000_0800);
		rd(OFS_TIMERS, 32'h8000_0000);
		rd(OFS_OPMODE, 32'h0000_0002);
		rd(8'h60, 32'h0000_0000);
		chk("vga", {31'h0, vga_decode_en}, 32'h0000_0001);
		// overrides clear: built-in timer values pass through
		chk("replay", {20'h0, replay_timeout}, 32'h0000_00a5);
		chk("ack", {18'h0, ack_latency}, 32'h0000_1234);
		// host cannot touch the read-only bits of the timer word
		wr(OFS_TIMERS, 32'hffff_ffff, 4'hf);
		rd(OFS_TIMERS, 32'hffff_1fff);
		chk("replay", {20'h0, replay_timeout}, 32'h0000_0fff);
		chk("ack", {18'h0, ack_latency}, 32'h0000_3fff);
		wr(OFS_TIMERS, 32'h0000_0123, 4'hf);
		tick(2);
		chk("replay", {20'h0, replay_timeout}, 32'h0000_00a5);
		chk("ack", {18'h0, ack_latency}, 32'h0000_1234);
		// byte lanes on the test words
		wr(OFS_TEST_A, 32'h1122_3344, 4'h5);
		rd(OFS_TEST_A, 32'h0422_1044);
		wr(OFS_TEST_B, 32'hdead_beef, 4'hf);
		tick(1);
		chk("test_b", test_word_b, 32'hdead_beef);
		chk("test_a", test_word_a, 32'h0422_1044);
		// every threshold code, then store-forward
		for (i = 0; i < 4; i++) begin
			wr(OFS_OPMODE, 32'(i) << 1, 4'hf);
			tick(1);
			chk("ct", {30'h0, ct_threshold}, 32'(i));
			chk("sf", {31'h0, store_forward}, 32'h0000_0000);
		end
		wr(OFS_OPMODE, 32'hffff_fff1, 4'hf);
		rd(OFS_OPMODE, 32'h0000_0001);
		chk("sf", {31'h0, store_forward}, 32'h0000_0001);
		// loader replaces defaults, including read-only bits
		ld(OFS_TIMERS, 32'h0000_6000);
		rd(OFS_TIMERS, 32'h0000_6000);
		chk("pm", {31'h0, pm_cap_disable}, 32'h0000_0001);
		chk("msi", {31'h0, msi_cap_disable}, 32'h0000_0001);
		chk("vga", {31'h0, vga_decode_en}, 32'h0000_0000);
		wr(OFS_TIMERS, 32'hffff_ffff, 4'hf);
		rd(OFS_TIMERS, 32'h7fff_7fff);
		ld(OFS_OPMODE, 32'h0000_0004);
		tick(1);
		chk("ct", {30'h0, ct_threshold}, 32'h0000_0002);
		// arbiter: credit-aware move, then hold, then release
		@(posedge sys_clk);
		port_req <= 4'h1;
		port_credit_ok <= 4'h1;
		tick(2);
		chk("grant", {28'h0, port_grant}, 32'h0000_0001);
		@(posedge sys_clk);
		port_req <= 4'h3;
		port_credit_ok <= 4'h2;
		tick(2);
		chk("grant", {28'h0, port_grant}, 32'h0000_0002);
		wr(OFS_OPMODE, 32'h0000_0008, 4'hf);
		port_credit_ok <= 4'h1;
		tick(3);
		chk("grant", {28'h0, port_grant}, 32'h0000_0002);
		wr(OFS_OPMODE, 32'h0000_0000, 4'hf);
		tick(2);
		chk("grant", {28'h0, port_grant}, 32'h0000_0001);
		@(posedge sys_clk);
		port_req <= 4'h0;
		tick(2);
		chk("gvalid", {31'h0, grant_valid}, 32'h0000_0000);
		// msi write with a stalling far side, second trigger mid-send
		wr(OFS_MSI_DATA, 32'hffff_abcd, 4'hf);
		rd(OFS_MSI_DATA, 32'h0000_abcd);
		@(posedge sys_clk);
		msi_enable <= 1'b1;
		msi_addr <= 30'h2aa5_5a5a;
		snk_delay <= 4'h3;
		n0 = n_wr;
		@(posedge sys_clk);
		msi_trigger <= 1'b1;
		@(posedge sys_clk);
		msi_trigger <= 1'b0;
		repeat (2) @(posedge sys_clk);
		msi_trigger <= 1'b1;
		@(posedge sys_clk);
		msi_trigger <= 1'b0;
		for (i = 0; i < 30 && n_wr !== n0 + 8'h02; i++) tick(1);
		chk("n_wr", {24'h0, n_wr}, {24'h0, n0} + 32'h2);
		chk("maddr", got_addr, 32'haa95_6968);
		chk("mdata", {16'h0, got_data}, 32'h0000_abcd);
		// disabled msi drops the trigger
		@(posedge sys_clk);
		msi_enable <= 1'b0;
		msi_trigger <= 1'b1;
		@(posedge sys_clk);
		msi_trigger <= 1'b0;
		tick(10);
		chk("n_wr", {24'h0, n_wr}, {24'h0, n0} + 32'h2);
		results();
	end
endmodule
`default_nettype wire
